// >>> design/prl_route_lock.sv
// register bank for pwm output routing, configuration lock and diagnostic options
`timescale 1ns/1ps
module prl_route_lock
    import prl_pkg::*;
#(
    parameter int NUM_CH = 8
)
(
    input  wire logic               clk,
    input  wire logic               srst,
    input  wire logic               frame_valid,
    input  wire logic [FRAME_W-1:0] frame_data,
    input  wire logic               gen0_pwm,
    input  wire logic               gen1_pwm,
    input  wire logic               overtemp_event,
    output logic                    rd_valid,
    output logic      [DATA_W-1:0]  rd_data,
    output logic      [NUM_CH-1:0]  route_drive,
    output logic      [NUM_CH-1:0]  route_active,
    output logic      [NUM_CH-1:0]  error_latch_clear_bit,
    output logic                    open_load_wait_select,
    output logic      [OL_WAIT_W-1:0] open_load_wait_cycles,
    output logic                    slew_select,
    output logic                    locked
);

    // channel count must fit an 8-bit register
    if (NUM_CH < 1 || NUM_CH > DATA_W)
    begin : g_bad_ch
        $error("NUM_CH must be between 1 and 8");
    end

    // register contents
    logic [NUM_CH-1:0] route_enable;
    logic [NUM_CH-1:0] gen_select;
    logic              overtemp_warning_flag;
    logic [NUM_CH-1:0] next_drive;

    // frame decode
    logic              wr_req;
    logic              rd_req;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [2:0]        lock_wr;
    logic              wr_cfg;
    logic              wr_open;

    assign wr_req  = frame_valid && frame_data[FRM_WR_BIT] && !frame_data[FRM_RD_BIT];
    assign rd_req  = frame_valid && !frame_data[FRM_WR_BIT] && frame_data[FRM_RD_BIT];
    assign addr    = frame_addr(frame_data);
    assign wdata   = frame_data[DATA_W-1:0];
    assign lock_wr = wdata[LOCK_HI:LOCK_LO];
    assign wr_cfg  = wr_req && (addr == ADDR_LOCK_DIAG_CFG);
    assign wr_open = wr_req && !locked;                                   // [RULE4]

    // lock state: only the exact codes move it
    always_ff @(posedge clk)
    begin
        if (srst)
            locked <= 1'b0;                                               // [RULE11]
        else if (wr_cfg && !locked && lock_wr == LOCK_CODE)
            locked <= 1'b1;                                               // [RULE4] [RULE5]
        else if (wr_cfg && locked && lock_wr == UNLOCK_CODE)
            locked <= 1'b0;                                               // [RULE6] [RULE7]
    end

    // routing registers, writable only while unlocked
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            route_enable <= NUM_CH'(ROUTE_ENABLE_RST);                    // [RULE1]
            gen_select   <= NUM_CH'(GEN_SELECT_RST);                      // [RULE2]
        end
        else
        begin
            if (wr_open && addr == ADDR_ROUTE_ENABLE)
                route_enable <= wdata[NUM_CH-1:0];                        // [RULE12]
            if (wr_open && addr == ADDR_GEN_SELECT)
                gen_select <= wdata[NUM_CH-1:0];                          // [RULE12]
        end
    end

    // diagnostic options, writable only while unlocked
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            open_load_wait_select <= LOCK_DIAG_CFG_RST[OL_WAIT_BIT];
            slew_select           <= LOCK_DIAG_CFG_RST[SLEW_BIT];
        end
        else if (wr_open && wr_cfg)
        begin
            open_load_wait_select <= wdata[OL_WAIT_BIT];                  // [RULE9]
            slew_select           <= wdata[SLEW_BIT];                     // [RULE10]
        end
    end

    // wait time count follows its select bit
    always_ff @(posedge clk)
    begin
        if (srst)
            open_load_wait_cycles <= OL_WAIT_SHORT_CYC;
        else if (wr_open && wr_cfg)
            open_load_wait_cycles <= wdata[OL_WAIT_BIT] ? OL_WAIT_LONG_CYC
                                                        : OL_WAIT_SHORT_CYC; // [RULE9]
    end

    // over-temperature warning mirrors the thermal comparator level
    always_ff @(posedge clk)
    begin
        if (srst)
            overtemp_warning_flag <= LOCK_DIAG_CFG_RST[OVERTEMP_BIT];
        else
            overtemp_warning_flag <= overtemp_event;                      // [RULE8]
    end

    // latch clear pulses pass even while locked
    always_ff @(posedge clk)
    begin
        if (srst)
            error_latch_clear_bit <= '0;
        else if (wr_req && addr == ADDR_CLEAR_LATCH)
            error_latch_clear_bit <= wdata[NUM_CH-1:0];                   // [RULE4]
        else
            error_latch_clear_bit <= '0;
    end

    // generator selection per channel
    prl_route_mux #(
        .NUM_CH       (NUM_CH)
    ) i_prl_route_mux (
        .route_enable (route_enable),
        .gen_select   (gen_select),
        .gen0_pwm     (gen0_pwm),
        .gen1_pwm     (gen1_pwm),
        .next_drive   (next_drive)
    );

    // registered channel drive and control ownership
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            route_drive  <= '0;
            route_active <= '0;
        end
        else
        begin
            route_drive  <= next_drive;                                   // [RULE1] [RULE2]
            route_active <= route_enable;                                 // [RULE3]
        end
    end

    // read answer one cycle after the frame; unmapped codes read zero
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rd_valid <= 1'b0;
            rd_data  <= '0;
        end
        else
        begin
            rd_valid <= rd_req;
            if (rd_req)
            begin
                case (addr)
                    ADDR_ROUTE_ENABLE:  rd_data <= DATA_W'(route_enable); // [RULE12]
                    ADDR_GEN_SELECT:    rd_data <= DATA_W'(gen_select);   // [RULE12]
                    ADDR_LOCK_DIAG_CFG: rd_data <= {(locked ? LOCK_CODE : UNLOCK_CODE),
                                                    2'b00,                // [RULE12]
                                                    overtemp_warning_flag, // [RULE8]
                                                    open_load_wait_select,
                                                    slew_select};
                    default:            rd_data <= '0;
                endcase
            end
        end
    end

    // lock code while unlocked locks at the next edge
    property p_lock_sets;
        @(posedge clk) disable iff (srst)
        (wr_cfg && !locked && lock_wr == LOCK_CODE) |=> locked;
    endproperty
    a_lock_sets: assert property (p_lock_sets) // [RULE4]
        else $error("lock code did not lock");

    // other codes while unlocked leave it unlocked
    property p_lock_other;
        @(posedge clk) disable iff (srst)
        (wr_cfg && !locked && lock_wr != LOCK_CODE) |=> !locked;
    endproperty
    a_lock_other: assert property (p_lock_other) // [RULE5]
        else $error("stray code locked");

    // unlock code while locked unlocks
    property p_unlock;
        @(posedge clk) disable iff (srst)
        (wr_cfg && locked && lock_wr == UNLOCK_CODE) |=> !locked;
    endproperty
    a_unlock: assert property (p_unlock) // [RULE6]
        else $error("unlock code did not unlock");

    // other codes while locked keep the lock
    property p_stay_locked;
        @(posedge clk) disable iff (srst)
        (locked && !(wr_cfg && lock_wr == UNLOCK_CODE)) |=> locked;
    endproperty
    a_stay_locked: assert property (p_stay_locked) // [RULE7]
        else $error("lock dropped");

    // locked writes do not move routing or options
    property p_locked_ignore;
        @(posedge clk) disable iff (srst)
        locked |=> ($stable(route_enable) && $stable(gen_select) && $stable(slew_select)
                    && $stable(open_load_wait_select));
    endproperty
    a_locked_ignore: assert property (p_locked_ignore) // [RULE4]
        else $error("write taken while locked");

    // disabled channels are never driven
    property p_route_off;
        @(posedge clk) disable iff (srst)
        !srst |=> ((route_drive & ~$past(route_enable)) == '0);
    endproperty
    a_route_off: assert property (p_route_off) // [RULE1]
        else $error("disabled channel driven");

    // enabled channels follow the chosen generator
    property p_route_sel;
        @(posedge clk) disable iff (srst)
        !srst |=> ((route_drive & $past(route_enable)) == ($past(route_enable)
                   & (($past(gen_select) & {NUM_CH{$past(gen1_pwm)}})
                   | (~$past(gen_select) & {NUM_CH{$past(gen0_pwm)}}))));
    endproperty
    a_route_sel: assert property (p_route_sel) // [RULE2]
        else $error("wrong generator on channel");

    // accepted routing write reads back on a read in the next cycle
    property p_readback;
        @(posedge clk) disable iff (srst)
        (wr_open && addr == ADDR_ROUTE_ENABLE) ##1 (rd_req && addr == ADDR_ROUTE_ENABLE)
        |=> (rd_valid && rd_data == DATA_W'(route_enable));
    endproperty
    a_readback: assert property (p_readback) // [RULE12]
        else $error("route enable readback wrong");

    // wait count always matches its select bit
    property p_wait;
        @(posedge clk) disable iff (srst)
        open_load_wait_cycles == (open_load_wait_select ? OL_WAIT_LONG_CYC : OL_WAIT_SHORT_CYC);
    endproperty
    a_wait: assert property (p_wait) // [RULE9]
        else $error("open load wait count mismatch");

    // read answer shows the warning flag in bit 2, reserved bits read zero
    property p_overtemp;
        @(posedge clk) disable iff (srst)
        (rd_req && addr == ADDR_LOCK_DIAG_CFG)
        |=> (rd_data[OVERTEMP_BIT] == $past(overtemp_warning_flag)
             && rd_data[RESERVED_HI:RESERVED_LO] == 2'b00);
    endproperty
    a_overtemp: assert property (p_overtemp) // [RULE8]
        else $error("lock register read wrong");

    // after reset the lock field shows the unlock code
    property p_reset_unlocked;
        @(posedge clk)
        srst |=> (!locked && route_enable == '0 && gen_select == '0 && !slew_select);
    endproperty
    a_reset_unlocked: assert property (p_reset_unlocked) // [RULE11]
        else $error("bad reset state");

    // a set slew bit in an accepted write selects the fast rate
    property p_slew_fast;
        @(posedge clk) disable iff (srst)
        (wr_open && wr_cfg && wdata[SLEW_BIT]) |=> slew_select;
    endproperty
    a_slew_fast: assert property (p_slew_fast) // [RULE10]
        else $error("slew select not set");

    // a clear slew bit in an accepted write selects the slow rate
    property p_slew_slow;
        @(posedge clk) disable iff (srst)
        (wr_open && wr_cfg && !wdata[SLEW_BIT]) |=> !slew_select;
    endproperty
    a_slew_slow: assert property (p_slew_slow) // [RULE10]
        else $error("slew select not cleared");

    // clear pulses last one cycle and only follow a clear frame
    property p_clear_idle;
        @(posedge clk) disable iff (srst)
        !(wr_req && addr == ADDR_CLEAR_LATCH) |=> (error_latch_clear_bit == '0);
    endproperty
    a_clear_idle: assert property (p_clear_idle) // [RULE4]
        else $error("stray latch clear pulse");

    // read answer strobe only follows a read frame
    property p_rd_once;
        @(posedge clk) disable iff (srst)
        !rd_req |=> !rd_valid;
    endproperty
    a_rd_once: assert property (p_rd_once) // [RULE12]
        else $error("read strobe without a read frame");

    // control ownership copies route enable one cycle later
    property p_active;
        @(posedge clk) disable iff (srst)
        1'b1 |=> (route_active == $past(route_enable));
    endproperty
    a_active: assert property (p_active) // [RULE3]
        else $error("route active does not follow route enable");

endmodule

// >>> design/prl_pkg.sv
// constants for the pwm routing and configuration lock register bank
// Behaviour
// RULE1 - Route-enable at 1 hands an output to a pwm generator; at 0, the reset value, to neither.
// RULE2 - Generator-select at 0, the reset value, picks generator 0 and at 1 picks generator 1.
// RULE3 - Generator-select matters only while route-enable is set, which the host must do first.
// RULE4 - Writing 110b to bits 7-5 ignores later writes except to lock field and latch clears.
// RULE5 - While unlocked, any other value written to the lock field leaves the lock state alone.
// RULE6 - Writing the unlock code 011b into the lock field makes every register writable again.
// RULE7 - While locked, any value other than the unlock code keeps the registers locked.
// RULE8 - Read-only bit 2 of the lock register is 1 on an over-temperature event, 0 otherwise.
// RULE9 - Bit 1 sets the open-load-at-on wait time: 58 us at 0 (the default), 80 us at 1.
// RULE10 - Bit 0 sets the output slew rate: 1.3 V/us at 0 (the default), 3 V/us at 1.
// RULE11 - After reset the lock field holds the unlock code, matching the register default 0x60.
// RULE12 - Bits 4-3 read zero; route and select read back the last accepted write.
package prl_pkg;

    // frame layout: bit 15 write flag, bit 14 read flag, bits 13-8 register code
    localparam int FRAME_W       = 16;
    localparam int FRM_WR_BIT    = 15;
    localparam int FRM_RD_BIT    = 14;
    localparam int FRM_ADDR_HI   = 13;
    localparam int FRM_ADDR_LO   = 8;
    localparam int ADDR_W        = 6;
    localparam int DATA_W        = 8;

    // register codes (bits 13-8 of the frame)
    localparam logic [ADDR_W-1:0] ADDR_CLEAR_LATCH   = 6'h0d; // 0011_01
    localparam logic [ADDR_W-1:0] ADDR_ROUTE_ENABLE  = 6'h24; // 1001_00
    localparam logic [ADDR_W-1:0] ADDR_GEN_SELECT    = 6'h25; // 1001_01
    localparam logic [ADDR_W-1:0] ADDR_LOCK_DIAG_CFG = 6'h28; // 1010_00

    // lock register field positions
    localparam int LOCK_HI       = 7;
    localparam int LOCK_LO       = 5;
    localparam int RESERVED_HI   = 4;
    localparam int RESERVED_LO   = 3;
    localparam int OVERTEMP_BIT  = 2;
    localparam int OL_WAIT_BIT   = 1;
    localparam int SLEW_BIT      = 0;

    // lock codes and reset values
    localparam logic [2:0]        LOCK_CODE          = 3'h6;
    localparam logic [2:0]        UNLOCK_CODE        = 3'h3;
    localparam logic [DATA_W-1:0] ROUTE_ENABLE_RST   = 8'h00;
    localparam logic [DATA_W-1:0] GEN_SELECT_RST     = 8'h00;
    localparam logic [DATA_W-1:0] LOCK_DIAG_CFG_RST  = 8'h60;

    // open-load wait times in ns, and their counts at the 100 ns clock
    localparam int CLK_PERIOD_NS    = 100;
    localparam int OL_WAIT_SHORT_NS = 58000;
    localparam int OL_WAIT_LONG_NS  = 80000;
    localparam int OL_WAIT_W        = 10;
    localparam logic [OL_WAIT_W-1:0] OL_WAIT_SHORT_CYC =
        OL_WAIT_W'((OL_WAIT_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [OL_WAIT_W-1:0] OL_WAIT_LONG_CYC =
        OL_WAIT_W'((OL_WAIT_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // slew rates in mV per us
    localparam int SLEW_SLOW_MV_PER_US = 1300;
    localparam int SLEW_FAST_MV_PER_US = 3000;

    // register code of a frame
    function automatic logic [ADDR_W-1:0] frame_addr(input logic [FRAME_W-1:0] frame);
        frame_addr = frame[FRM_ADDR_HI:FRM_ADDR_LO];
    endfunction

endpackage

// >>> design/prl_route_mux.sv
// per-channel selection of the pwm generator that drives each output
`timescale 1ns/1ps
module prl_route_mux
    import prl_pkg::*;
#(
    parameter int NUM_CH = 8
)
(
    input  wire logic [NUM_CH-1:0] route_enable,
    input  wire logic [NUM_CH-1:0] gen_select,
    input  wire logic              gen0_pwm,
    input  wire logic              gen1_pwm,
    output logic      [NUM_CH-1:0] next_drive
);

    // a disabled channel stays low whatever its select bit says
    always_comb
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (route_enable[i])                                          // [RULE1] [RULE3]
                next_drive[i] = gen_select[i] ? gen1_pwm : gen0_pwm;      // [RULE2]
            else
                next_drive[i] = 1'b0;
        end
    end

endmodule

// >>> bench/prl_host_model.sv
// host-side model that issues decoded control frames to the register bank
`timescale 1ns/1ps
module prl_host_model
    import prl_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rd_valid,
    input  wire logic [DATA_W-1:0]  rd_data,
    output logic                    frame_valid,
    output logic      [FRAME_W-1:0] frame_data
);
    // bus idles with no frame marked
    initial
    begin
        frame_valid = 1'b0;
        frame_data  = 16'h0000;
    end

    // one frame held over exactly one taking edge, then the bus shows its inverse
    task automatic send(input logic [FRAME_W-1:0] frm);
        @(posedge clk);
        frame_valid <= 1'b1;
        frame_data  <= frm;
        @(posedge clk);
        frame_valid <= 1'b0;
        frame_data  <= ~frm;
        #1;
    endtask

    // register write frame
    task automatic wr(input logic [ADDR_W-1:0] code, input logic [DATA_W-1:0] val);
        send({2'b10, code, val});
    endtask

    // read frame; the answer is sampled just after the taking edge
    task automatic read(input logic [ADDR_W-1:0] code, output logic [DATA_W-1:0] val,
                        output logic ok);
        send({2'b01, code, 8'h00});
        ok  = rd_valid;
        val = rd_data;
    endtask

    // write then read in back-to-back frames; the read answer is due after the third edge
    task automatic wr_rd(input logic [ADDR_W-1:0] code, input logic [DATA_W-1:0] wval,
                         output logic [DATA_W-1:0] val, output logic ok);
        @(posedge clk);
        frame_valid <= 1'b1;
        frame_data  <= {2'b10, code, wval};
        @(posedge clk);
        frame_data  <= {2'b01, code, 8'h00};
        @(posedge clk);
        frame_valid <= 1'b0;
        frame_data  <= ~{2'b01, code, 8'h00};
        #1;
        ok  = rd_valid;
        val = rd_data;
    endtask
endmodule

// >>> bench/tb.sv
// self-checking testbench for the routing and lock register bank
`timescale 1ns/1ps
module tb
    import prl_pkg::*;
;
    logic                 clk, srst, frame_valid, gen0_pwm, gen1_pwm, overtemp_event;
    logic                 rd_valid, open_load_wait_select, slew_select, locked, ok;
    logic [FRAME_W-1:0]   frame_data;
    logic [DATA_W-1:0]    rd_data, rv;
    logic [7:0]           route_drive, route_active, error_latch_clear_bit;
    logic [OL_WAIT_W-1:0] open_load_wait_cycles;
    int                   error_cnt, check_count;

    prl_route_lock #(.NUM_CH(8)) i_prl_route_lock (.clk(clk), .srst(srst),
        .frame_valid(frame_valid), .frame_data(frame_data), .gen0_pwm(gen0_pwm),
        .gen1_pwm(gen1_pwm), .overtemp_event(overtemp_event), .rd_valid(rd_valid),
        .rd_data(rd_data), .route_drive(route_drive), .route_active(route_active),
        .error_latch_clear_bit(error_latch_clear_bit),
        .open_load_wait_select(open_load_wait_select),
        .open_load_wait_cycles(open_load_wait_cycles), .slew_select(slew_select),
        .locked(locked));

    prl_host_model i_prl_host_model (.clk(clk), .rd_valid(rd_valid), .rd_data(rd_data),
        .frame_valid(frame_valid), .frame_data(frame_data));

    // compare one observed value with its expectation
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // print counts and verdict, then stop
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // read a register and compare both the answer strobe and the data
    task automatic rd(input logic [ADDR_W-1:0] code, input logic [DATA_W-1:0] exp);
        i_prl_host_model.read(code, rv, ok);
        check(16'(ok), 16'h0001);
        check(16'(rv), 16'(exp));
    endtask

    // set both generator levels, let the drive register catch up, compare
    task automatic gen(input logic g0, input logic g1, input logic [7:0] exp);
        @(posedge clk);
        gen0_pwm <= g0;
        gen1_pwm <= g1;
        repeat (2) @(posedge clk);
        #1;
        check(16'(route_drive), 16'(exp));
    endtask

    // outputs and registers straight after reset
    task automatic t_reset();
        check(16'(route_drive), 16'h0000);
        check(16'(locked), 16'h0000);
        check(16'(open_load_wait_cycles), 16'(OL_WAIT_SHORT_CYC));
        check(16'(slew_select), 16'h0000);
        rd(ADDR_ROUTE_ENABLE, 8'h00);
        rd(ADDR_GEN_SELECT, 8'h00);
        rd(ADDR_LOCK_DIAG_CFG, 8'h60);
    endtask

    // per-channel routing with every generator level combination
    task automatic t_route();
        i_prl_host_model.wr(ADDR_ROUTE_ENABLE, 8'ha5);
        i_prl_host_model.wr(ADDR_GEN_SELECT, 8'h0f);
        check(16'(route_active), 16'h00a5);
        gen(1'b1, 1'b0, 8'ha0);
        gen(1'b0, 1'b1, 8'h05);
        gen(1'b1, 1'b1, 8'ha5);
        gen(1'b0, 1'b0, 8'h00);
        gen(1'b1, 1'b0, 8'ha0);
        rd(ADDR_ROUTE_ENABLE, 8'ha5);
        rd(ADDR_GEN_SELECT, 8'h0f);
    endtask

    // option bits, reserved bits, warning flag and non-lock codes while unlocked
    task automatic t_config();
        i_prl_host_model.wr(ADDR_LOCK_DIAG_CFG, 8'h7f);
        check(16'(locked), 16'h0000);
        check(16'(open_load_wait_select), 16'h0001);
        check(16'(open_load_wait_cycles), 16'(OL_WAIT_LONG_CYC));
        check(16'(slew_select), 16'h0001);
        rd(ADDR_LOCK_DIAG_CFG, 8'h63);
        i_prl_host_model.wr(ADDR_LOCK_DIAG_CFG, 8'ha0);
        check(16'(locked), 16'h0000);
        check(16'(open_load_wait_cycles), 16'(OL_WAIT_SHORT_CYC));
        @(posedge clk);
        overtemp_event <= 1'b1;
        rd(ADDR_LOCK_DIAG_CFG, 8'h64);
        @(posedge clk);
        overtemp_event <= 1'b0;
        rd(ADDR_LOCK_DIAG_CFG, 8'h60);
    endtask

    // lock, refused writes, clear pulses while locked, then unlock
    task automatic t_lock();
        i_prl_host_model.wr(ADDR_LOCK_DIAG_CFG, 8'hc1);
        check(16'(locked), 16'h0001);
        i_prl_host_model.wr(ADDR_ROUTE_ENABLE, 8'hff);
        i_prl_host_model.wr(ADDR_GEN_SELECT, 8'hff);
        i_prl_host_model.wr(ADDR_LOCK_DIAG_CFG, 8'he2);
        check(16'(locked), 16'h0001);
        rd(ADDR_LOCK_DIAG_CFG, 8'hc1);
        rd(ADDR_ROUTE_ENABLE, 8'ha5);
        rd(ADDR_GEN_SELECT, 8'h0f);
        i_prl_host_model.wr(ADDR_CLEAR_LATCH, 8'h81);
        check(16'(error_latch_clear_bit), 16'h0081);
        @(posedge clk);
        #1;
        check(16'(error_latch_clear_bit), 16'h0000);
        i_prl_host_model.wr(ADDR_LOCK_DIAG_CFG, 8'h60);
        check(16'(locked), 16'h0000);
        rd(ADDR_LOCK_DIAG_CFG, 8'h61);
        i_prl_host_model.wr(ADDR_ROUTE_ENABLE, 8'h3c);
        rd(ADDR_ROUTE_ENABLE, 8'h3c);
    endtask

    // unmapped code, a frame with both flags, and a write read back in the next frame
    task automatic t_misc();
        rd(6'h3f, 8'h00);
        i_prl_host_model.send({2'b11, ADDR_ROUTE_ENABLE, 8'hff});
        rd(ADDR_ROUTE_ENABLE, 8'h3c);
        i_prl_host_model.wr_rd(ADDR_ROUTE_ENABLE, 8'h5a, rv, ok);
        check(16'(ok), 16'h0001);
        check(16'(rv), 16'h005a);
    endtask

    // reset in mid-run while locked puts the lock register and route enable back to their defaults
    task automatic t_rst();
        i_prl_host_model.wr(ADDR_LOCK_DIAG_CFG, 8'hc3);
        check(16'(locked), 16'h0001);
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        check(16'(locked), 16'h0000);
        check(16'(slew_select), 16'h0000);
        check(16'(open_load_wait_select), 16'h0000);
        check(16'(open_load_wait_cycles), 16'(OL_WAIT_SHORT_CYC));
        rd(ADDR_ROUTE_ENABLE, 8'h00);
        rd(ADDR_LOCK_DIAG_CFG, 8'h60);
    endtask

    // free-running clock
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // reset, then the scenarios in turn
    initial
    begin
        srst           = 1'b1;
        gen0_pwm       = 1'b0;
        gen1_pwm       = 1'b0;
        overtemp_event = 1'b0;
        error_cnt      = 0;
        check_count    = 0;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        t_reset();
        t_route();
        t_config();
        t_lock();
        t_misc();
        t_rst();
        end_of_test();
    end

    // watchdog against a hang
    initial
    begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        end_of_test();
    end
endmodule
